// ### verilog/boidec_pkg.sv
// Package: encodings, field positions and constants for the bit-op / interrupt-return decoder
package boidec_pkg;

  // ==========================================================
  // Widths
  localparam int INSN_W  = 14;
  localparam int PC_W    = 13;
  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 8;
  localparam int STACK_D = 8;
  localparam int SP_W    = 3;

  // ==========================================================
  // Encodings
  localparam logic [1:0]  OPC_CLASS_BIT  = 2'h1;
  localparam logic [1:0]  BITOP_CLEAR    = 2'h0;
  localparam logic [1:0]  BITOP_SET      = 2'h1;
  localparam logic [1:0]  BITOP_TEST_CLR = 2'h2;
  localparam logic [13:0] INSN_IRQ_RET   = 14'h0009;
  localparam logic [13:0] INSN_NOP       = 14'h0000;

  // ==========================================================
  // Field positions
  localparam int CLASS_MSB  = 13;
  localparam int CLASS_LSB  = 12;
  localparam int BITOP_MSB  = 11;
  localparam int BITOP_LSB  = 10;
  localparam int BIDX_MSB   = 9;
  localparam int BIDX_LSB   = 7;
  localparam int FADDR_MSB  = 6;
  localparam int FADDR_LSB  = 0;
  localparam int GIE_BIT    = 7;

  // ==========================================================
  // Reset values and vector
  localparam logic [12:0] PC_RESET   = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic        GIE_RESET  = 1'b0;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              we;
  } boidec_fwr_s;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_FLUSH = 3'b010,
    ST_IRQ   = 3'b100
  } boidec_state_e;

endpackage

// ### verilog/boidec_core.sv
// Decode and execute of bit clear/set/test-skip and interrupt return
`timescale 1ns/1ps
module boidec_core (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  // Fetch path
  input  wire logic [13:0]                   fetch_insn,
  input  wire logic                          irq_req,
  output logic [12:0]                        pc_out,
  // File register port
  input  wire logic [7:0]                    file_rdata,
  output logic [6:0]                         file_raddr,
  output boidec_pkg::boidec_fwr_s            file_wr,
  // Interrupt control and status
  output logic                               global_irq_enable,
  output logic                               status_we,
  output logic [2:0]                         stack_depth
);

  // ==========================================================
  // Decode
  wire [1:0] insn_class = fetch_insn[boidec_pkg::CLASS_MSB:boidec_pkg::CLASS_LSB];
  wire [1:0] bitop      = fetch_insn[boidec_pkg::BITOP_MSB:boidec_pkg::BITOP_LSB];
  wire [2:0] bidx       = fetch_insn[boidec_pkg::BIDX_MSB:boidec_pkg::BIDX_LSB];
  wire [6:0] faddr      = fetch_insn[boidec_pkg::FADDR_MSB:boidec_pkg::FADDR_LSB];

  boidec_pkg::boidec_state_e state_reg;
  boidec_pkg::boidec_state_e state_next;
  logic                      global_irq_enable_reg;

  wire       in_exec    = (state_reg == boidec_pkg::ST_EXEC);
  wire       is_bitcls  = in_exec && (insn_class == boidec_pkg::OPC_CLASS_BIT);
  wire       bit_clear_op = is_bitcls && (bitop == boidec_pkg::BITOP_CLEAR);
  wire       bit_set_op   = is_bitcls && (bitop == boidec_pkg::BITOP_SET);
  wire       bit_test_op  = is_bitcls && (bitop == boidec_pkg::BITOP_TEST_CLR);
  wire       interrupt_return_op = in_exec && (fetch_insn == boidec_pkg::INSN_IRQ_RET);
  wire       take_irq   = in_exec && irq_req && global_irq_enable_reg && !interrupt_return_op;
  wire [7:0] bit_mask   = 8'h01 << bidx;
  wire       sel_bit    = |(file_rdata & bit_mask);
  wire       skip_taken = bit_test_op && !sel_bit;

  // ==========================================================
  // Return stack
  logic [12:0] stack_mem [0:boidec_pkg::STACK_D-1];
  logic [2:0]  sp_reg;
  logic [12:0] pc_reg;
  boidec_pkg::boidec_fwr_s file_wr_reg;

  wire [2:0]  sp_top       = sp_reg - 3'h1;
  wire [12:0] stack_top_entry = stack_mem[sp_top];
  wire [12:0] pc_inc       = pc_reg + 13'h0001;
  wire [12:0] pc_skip      = pc_reg + 13'h0002;

  // Irq entry stalls one cycle, like the two-cycle branches
  always_comb
  begin
    state_next = boidec_pkg::ST_EXEC;
    case (state_reg)
      boidec_pkg::ST_EXEC:
      begin
        if (take_irq)
          state_next = boidec_pkg::ST_IRQ;
        else if (skip_taken || interrupt_return_op)
          state_next = boidec_pkg::ST_FLUSH;
      end
      boidec_pkg::ST_FLUSH: state_next = boidec_pkg::ST_EXEC;
      boidec_pkg::ST_IRQ:   state_next = boidec_pkg::ST_EXEC;
      default:              state_next = boidec_pkg::ST_EXEC;
    endcase
  end

  // Dead cycles hold pc, so the jump target is the next word executed
  wire [12:0] pc_next =
    !in_exec            ? pc_reg :
    take_irq            ? boidec_pkg::IRQ_VECTOR :
    interrupt_return_op ? stack_top_entry :
    skip_taken          ? pc_skip :
    pc_inc;

  wire [7:0] wr_data = bit_set_op ? (file_rdata | bit_mask)
                                  : (file_rdata & ~bit_mask);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg             <= boidec_pkg::ST_EXEC;
      pc_reg                <= boidec_pkg::PC_RESET;
      sp_reg                <= 3'h0;
      global_irq_enable_reg <= boidec_pkg::GIE_RESET;
      file_wr_reg           <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      // Ring stack: overflow wraps silently, as on the real core
      if (take_irq)
        sp_reg <= sp_reg + 3'h1;
      else if (interrupt_return_op)
        sp_reg <= sp_top;
      if (take_irq)
        global_irq_enable_reg <= 1'b0;
      else if (interrupt_return_op)
        global_irq_enable_reg <= 1'b1;
      file_wr_reg.addr <= faddr;
      file_wr_reg.data <= wr_data;
      file_wr_reg.we   <= (bit_clear_op || bit_set_op) && !take_irq;
    end
  end

  // Entries reset so a return on an empty stack lands on a known address
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < boidec_pkg::STACK_D; i++)
        stack_mem[i] <= boidec_pkg::PC_RESET;
    end
    else if (take_irq)
      stack_mem[sp_reg] <= pc_reg;
  end

  // ==========================================================
  // Outputs
  assign pc_out            = pc_reg;
  assign file_raddr        = faddr;
  assign file_wr           = file_wr_reg;
  assign global_irq_enable = global_irq_enable_reg;
  assign stack_depth       = sp_reg;
  assign status_we         = 1'b0;

  // ==========================================================
  // Checks
  property p_clear_bit;
    @(posedge ref_clk) disable iff (!rstn)
      (bit_clear_op && !take_irq) |=> (file_wr.we && !(file_wr.data[$past(bidx)]) && file_wr.addr == $past(faddr));
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear did not write zero");

  property p_set_bit;
    @(posedge ref_clk) disable iff (!rstn)
      (bit_set_op && !take_irq) |=> (file_wr.we && file_wr.data[$past(bidx)]);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set did not write one");

  property p_no_skip;
    @(posedge ref_clk) disable iff (!rstn)
      (bit_test_op && sel_bit && !take_irq) |=> (state_reg == boidec_pkg::ST_EXEC && pc_out == $past(pc_out) + 13'h0001);
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("test with bit set did skip");

  property p_skip_flush;
    @(posedge ref_clk) disable iff (!rstn)
      (skip_taken && !take_irq) |=> (state_reg == boidec_pkg::ST_FLUSH && !file_wr.we) ##1 (state_reg == boidec_pkg::ST_EXEC);
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("skip did not flush one cycle");

  property p_ret_pc;
    @(posedge ref_clk) disable iff (!rstn)
      interrupt_return_op |=> (pc_out == $past(stack_top_entry) && stack_depth == $past(stack_depth) - 3'h1);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return did not load top of stack");

  property p_ret_gie;
    @(posedge ref_clk) disable iff (!rstn)
      interrupt_return_op |=> global_irq_enable;
  endproperty
  a_ret_gie: assert property (p_ret_gie) else $error("return did not set enable");

  property p_ret_two;
    @(posedge ref_clk) disable iff (!rstn)
      interrupt_return_op |=> (state_reg == boidec_pkg::ST_FLUSH) ##1 (state_reg == boidec_pkg::ST_EXEC);
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_irq_entry;
    @(posedge ref_clk) disable iff (!rstn)
      take_irq |=> (!global_irq_enable && pc_out == boidec_pkg::IRQ_VECTOR && stack_depth == $past(stack_depth) + 3'h1);
  endproperty
  a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong");

  property p_no_status;
    @(posedge ref_clk) disable iff (!rstn)
      (is_bitcls || interrupt_return_op) |-> ##[0:1] !status_we;
  endproperty
  a_no_status: assert property (p_no_status) else $error("status flags written");

  property p_skip_pc;
    @(posedge ref_clk) disable iff (!rstn)
      (skip_taken && !take_irq) |=> (pc_out == $past(pc_out) + 13'h0002);
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip did not step over next word");

  property p_dead_nowr;
    @(posedge ref_clk) disable iff (!rstn)
      (state_reg != boidec_pkg::ST_EXEC) |=> !file_wr.we;
  endproperty
  a_dead_nowr: assert property (p_dead_nowr) else $error("discarded word was executed");

  // A dead cycle that moved pc would lose the jump target word
  property p_dead_hold;
    @(posedge ref_clk) disable iff (!rstn)
      (state_reg != boidec_pkg::ST_EXEC) |=> (pc_out == $past(pc_out));
  endproperty
  a_dead_hold: assert property (p_dead_hold) else $error("pc moved in dead cycle");

  property p_irq_masked;
    @(posedge ref_clk) disable iff (!rstn)
      (in_exec && irq_req && !global_irq_enable) |=> (state_reg != boidec_pkg::ST_IRQ);
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt taken while disabled");

endmodule // boidec_core

// ### sim/boidec_partner.sv
// Fetch path and file register model facing the decoder
`timescale 1ns/1ps
module boidec_partner (
  // Clock
  input  wire logic                    ref_clk,
  // Fetch path
  input  wire logic [12:0]             pc_out,
  output logic [13:0]                  fetch_insn,
  // File register port
  input  wire logic [6:0]              file_raddr,
  input  wire boidec_pkg::boidec_fwr_s file_wr,
  output logic [7:0]                   file_rdata
);
  // ==========================================================
  // Storage
  logic [13:0] prog [16];
  logic [7:0]  mem  [128];

  initial
  begin
    fetch_insn = 14'h0000;
    foreach (prog[i]) prog[i] = 14'h0000;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // Unknown or far pc fetches a no-op, not a stale word
  always @(negedge ref_clk)
    fetch_insn <= (pc_out[12:4] === 9'h000) ? prog[pc_out[3:0]] : boidec_pkg::INSN_NOP;

  assign file_rdata = mem[file_raddr];

  always @(posedge ref_clk)
    if (file_wr.we === 1'b1)
      mem[file_wr.addr] <= file_wr.data;
endmodule // boidec_partner

// ### sim/boidec_core_tb.sv
// Self-checking bench for the bit-op and interrupt-return decoder
`timescale 1ns/1ps
module boidec_core_tb;
  // ==========================================================
  // Signals
  logic                    ref_clk;
  logic                    rstn;
  logic                    irq_req;
  logic [13:0]             fetch_insn;
  logic [12:0]             pc_out;
  logic [7:0]              file_rdata;
  logic [6:0]              file_raddr;
  boidec_pkg::boidec_fwr_s file_wr;
  logic                    global_irq_enable;
  logic                    status_we;
  logic [2:0]              stack_depth;
  int                      n_mismatch = 0;
  int                      checks_done = 0;
  int                      cycles = 0;

  boidec_core i_boidec_core (.ref_clk(ref_clk), .rstn(rstn), .fetch_insn(fetch_insn), .irq_req(irq_req),
    .pc_out(pc_out), .file_rdata(file_rdata), .file_raddr(file_raddr), .file_wr(file_wr),
    .global_irq_enable(global_irq_enable), .status_we(status_we), .stack_depth(stack_depth));
  boidec_partner i_boidec_partner (.ref_clk(ref_clk), .pc_out(pc_out), .fetch_insn(fetch_insn),
    .file_raddr(file_raddr), .file_wr(file_wr), .file_rdata(file_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Whole run needs about twenty-five cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 500)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [13:0] bop(input logic [1:0] op, input int b, input int f);
    return {boidec_pkg::OPC_CLASS_BIT, op, 3'(b), 7'(f)};
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_bitops;
    logic [6:0] fa [4] = '{7'h20, 7'h21, 7'h7f, 7'h00};
    logic [7:0] da [4] = '{8'h8a, 8'h47, 8'h01, 8'hfe};
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      chk(file_wr, {fa[i], da[i], 1'b1});
      chk(16'(pc_out), 16'(i + 1));
    end
    chk(16'(status_we), 16'h0);
    $display("test bitops done");
  endtask

  task automatic t_skip;
    tick(1);
    chk(16'(pc_out), 16'h6);
    tick(1);
    chk(16'(pc_out), 16'h6);
    chk(16'(file_wr.we), 16'h0);
    tick(1);
    chk(16'(pc_out), 16'h7);
    tick(1);
    chk(file_wr, {7'h32, 8'h01, 1'b1});
    chk(16'(i_boidec_partner.mem[7'h31]), 16'h0);
    $display("test skip done");
  endtask

  task automatic t_irq;
    i_boidec_partner.prog[4] = bop(boidec_pkg::BITOP_SET, 1, 7'h40);
    i_boidec_partner.prog[5] = boidec_pkg::INSN_IRQ_RET;
    tick(1);
    chk(16'(pc_out), 16'h0);
    chk(16'(global_irq_enable), 16'h1);
    chk(16'(stack_depth), 16'h7);
    tick(1);
    chk(16'(pc_out), 16'h0);
    chk(16'(global_irq_enable), 16'h1);
    tick(1);
    @(negedge ref_clk);
    irq_req = 1'b1;
    tick(1);
    chk(16'(pc_out), 16'(boidec_pkg::IRQ_VECTOR));
    chk(16'(global_irq_enable), 16'h0);
    chk(16'(stack_depth), 16'h0);
    chk(16'(file_wr.we), 16'h0);
    tick(2);
    chk(file_wr, {7'h40, 8'h02, 1'b1});
    chk(16'(pc_out), 16'h5);
    tick(1);
    chk(16'(pc_out), 16'h1);
    chk(16'(global_irq_enable), 16'h1);
    chk(16'(stack_depth), 16'h7);
    tick(1);
    chk(16'(pc_out), 16'h1);
    chk(16'(global_irq_enable), 16'h1);
    tick(1);
    chk(16'(pc_out), 16'(boidec_pkg::IRQ_VECTOR));
    chk(16'(status_we), 16'h0);
    @(negedge ref_clk);
    irq_req = 1'b0;
    $display("test irq return done");
  endtask

  initial
  begin
    rstn = 1'b0;
    irq_req = 1'b0;
    tick(6);
    chk(16'(pc_out), 16'h0);
    chk(16'(global_irq_enable), 16'h0);
    i_boidec_partner.mem[7'h20] = 8'h0a;
    i_boidec_partner.mem[7'h21] = 8'hc7;
    i_boidec_partner.mem[7'h00] = 8'hff;
    i_boidec_partner.mem[7'h30] = 8'hf7;
    i_boidec_partner.prog[0] = bop(boidec_pkg::BITOP_SET, 7, 7'h20);
    i_boidec_partner.prog[1] = bop(boidec_pkg::BITOP_CLEAR, 7, 7'h21);
    i_boidec_partner.prog[2] = bop(boidec_pkg::BITOP_SET, 0, 7'h7f);
    i_boidec_partner.prog[3] = bop(boidec_pkg::BITOP_CLEAR, 0, 7'h00);
    i_boidec_partner.prog[4] = bop(boidec_pkg::BITOP_TEST_CLR, 3, 7'h30);
    i_boidec_partner.prog[5] = bop(boidec_pkg::BITOP_SET, 0, 7'h31);
    i_boidec_partner.prog[6] = bop(boidec_pkg::BITOP_TEST_CLR, 2, 7'h30);
    i_boidec_partner.prog[7] = bop(boidec_pkg::BITOP_SET, 0, 7'h32);
    i_boidec_partner.prog[8] = boidec_pkg::INSN_IRQ_RET;
    @(negedge ref_clk);
    rstn = 1'b1;
    t_bitops();
    t_skip();
    t_irq();
    final_report();
  end
endmodule // boidec_core_tb
